// ==== bench/dps_fb_master.sv ====
// fieldbus master model: plain register bus reads and writes
module dps_fb_master (
   input wire logic clk,
   output logic [15:0] reg_addr,
   output logic [31:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [31:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      reg_addr = 16'h0000;
      reg_wdata = 32'h00000000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // ------------------------------------------------------------
   // bus cycles
   // ------------------------------------------------------------
   // control requests are whole word writes
   task wr(input logic [15:0] a, input logic [31:0] dat);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= dat;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // data stand one cycle only, so sample mid cycle
   task rd(input logic [15:0] a, output logic [31:0] dat);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      dat = reg_rdata;
   endtask
endmodule

// ==== bench/dps_top_chk.sv ====
// concurrent checks on the drive object block ports
`include "dps_regs.vh"

module dps_top_chk (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [15:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic halt_mode_ok,
   input wire logic ballast_on,
   input wire logic halt_out,
   input wire logic power_stage_on
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // ------------------------------------------------------------
   // read sequences
   // ------------------------------------------------------------
   sequence st_rd;
      reg_rd && reg_addr == `DPS_A_STATUS;
   endsequence
   sequence ec_rd;
      reg_rd && reg_addr == `DPS_A_ERR_CODE;
   endsequence

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
      else $error("read data not zero outside read answer");
   remote_bit_a: assert property (st_rd |=> reg_rdata[`DPS_SW_REM])
      else $error("remote flag low");
   loop_flag_a: assert property (st_rd |=> !reg_rdata[15] || reg_rdata[6:0] == 7'h37)
      else $error("closed loop flag outside operation enabled");
   dis_code_a: assert property (st_rd |=> !reg_rdata[6] || reg_rdata[3:0] == 4'h0)
      else $error("disabled flag with low bits set");
   state_code_a: assert property (st_rd |=> reg_rdata[3:0] inside {4'h0, 4'h1, 4'h3, 4'h7,
      4'hF, 4'h8})
      else $error("status low bits decode to no state");
   stop_code_a: assert property (st_rd |=> reg_rdata[5] || reg_rdata[6:0] == 7'h17)
      else $error("quick stop flag in wrong state");
   err_high_a: assert property (ec_rd |=> reg_rdata[31:16] == 16'h0000)
      else $error("error code upper half not zero");
   bal_off_a: assert property (reg_wr && reg_addr == `DPS_A_BAL_SET && !reg_wdata[0]
      |-> ##[1:3] !ballast_on)
      else $error("ballast stays on after disable");
   halt_gate_a: assert property (halt_out |-> $past(halt_mode_ok) && power_stage_on)
      else $error("halt outside supported mode or enabled state");
endmodule

bind dps_top dps_top_chk u_chk (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .halt_mode_ok, .ballast_on, .halt_out, .power_stage_on);

// ==== bench/test_drive_power_state_objects.sv ====
// self-checking bench of the drive object block
`include "dps_regs.vh"

module test_drive_power_state_objects;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic fault_in = 1'b0;
   logic fsync = 1'b0;
   logic cl_on = 1'b1;
   logic target_reached_flag_in = 1'b0;
   logic ilim_in = 1'b0;
   logic hok = 1'b1;
   logic wrn = 1'b0;
   logic wexp = 1'b0;
   logic [31:0] supply_mv = 32'h00000000;
   logic [15:0] fault_code = 16'h0000;
   logic [31:0] d, thr, hys;
   logic [31:0] sv [5];
   logic [6:0] lo_tab [8] = '{7'h20, 7'h60, 7'h31, 7'h33, 7'h37, 7'h17, 7'h2F, 7'h28};
   wire [15:0] reg_addr;
   wire [31:0] reg_wdata, reg_rdata;
   wire reg_wr, reg_rd, ballast_on, halt_out, power_stage_on;
   int n_errors = 0;
   int num_checks = 0;

   dps_top #(.BOOT_MAJOR(16'h0004), .BOOT_MINOR(16'h0002), .BOOT_BUSES(32'h00000005)) u_dut (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .supply_mv(supply_mv),
      .fault_in(fault_in), .fault_code(fault_code), .warning_in(wrn),
      .fieldbus_sync(fsync), .closed_loop_on(cl_on), .target_reached_in(target_reached_flag_in),
      .internal_limit_in(ilim_in), .halt_mode_ok(hok), .ballast_on(ballast_on),
      .halt_out(halt_out), .power_stage_on(power_stage_on));
   dps_fb_master u_mst (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   initial forever #2.5 clk = ~clk;

   // ------------------------------------------------------------
   // compares and expectations
   // ------------------------------------------------------------
   task chk32(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task chk1(input logic got, input logic exp);
      chk32({31'h0, got}, {31'h0, exp});
   endtask
   task rdc(input logic [15:0] a, input logic [31:0] exp, input logic [31:0] mask);
      u_mst.rd(a, d);
      chk32(d & mask, exp);
   endtask
   // mode specific bits 14..12 are left unchecked
   function logic [31:0] exp_sw(input logic [2:0] st);
      exp_sw = {16'h0, st == 3'h4 && cl_on, 3'h0, ilim_in, target_reached_flag_in, 1'b1, fsync, wexp,
         lo_tab[st]};
   endfunction
   task ctl(input logic [15:0] c, input logic [2:0] st);
      u_mst.wr(`DPS_A_CTRL, {16'h0, c});
      repeat (3) @(posedge clk);
      rdc(`DPS_A_STATUS, exp_sw(st), 32'hFFFF8FFF);
      chk1(power_stage_on, st == 3'h4 || st == 3'h5);
   endtask
   task results;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      #50000;
      n_errors++;
      results();
   end

   initial begin
      void'($urandom(83548));
      fsync = $urandom;
      target_reached_flag_in = $urandom;
      ilim_in = $urandom;
      cl_on = $urandom;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk);
      rdc(`DPS_A_BAL_SET, 32'h00000001, 32'hFFFFFFFF);
      rdc(`DPS_A_BAL_THR, 32'h00012396, 32'hFFFFFFFF);
      rdc(`DPS_A_BAL_HYS, 32'h000001F4, 32'hFFFFFFFF);
      rdc(`DPS_A_ERR_CODE, 32'h00000000, 32'hFFFFFFFF);
      rdc(`DPS_A_STATUS, exp_sw(3'h1), 32'hFFFF8FFF);
      rdc(`DPS_A_BOOT_VER, 32'h00040002, 32'hFFFFFFFF);
      rdc(`DPS_A_BOOT_BUS, 32'h00000005, 32'hFFFFFFFF);
      u_mst.wr(`DPS_A_ERR_CODE, 32'hFFFFFFFF);
      rdc(`DPS_A_ERR_CODE, 32'h00000000, 32'hFFFFFFFF);
      rdc(16'h5000, 32'h00000000, 32'hFFFFFFFF);
      $display("test reset values done");
      ctl(16'h0006, 3'h2);
      ctl(16'h0007, 3'h3);
      ctl(16'h000F, 3'h4);
      ctl(16'h000B, 3'h5);
      ctl(16'h000F, 3'h4);
      u_mst.wr(`DPS_A_CTRL, 32'h0000010F);
      rdc(`DPS_A_CTRL, 32'h0000010F, 32'hFFFFFFFF);
      repeat (3) @(posedge clk);
      chk1(halt_out, 1'b1);
      hok <= 1'b0;
      repeat (3) @(posedge clk);
      chk1(halt_out, 1'b0);
      hok <= 1'b1;
      ctl(16'h0000, 3'h1);
      $display("test state walk done");
      @(posedge clk);
      fault_in <= 1'b1;
      wrn <= 1'b1;
      fault_code <= $urandom;
      @(posedge clk);
      fault_in <= 1'b0;
      wrn <= 1'b0;
      wexp = 1'b1;
      rdc(`DPS_A_STATUS, exp_sw(3'h6), 32'hFFFF8FFF);
      repeat (10) @(posedge clk);
      rdc(`DPS_A_STATUS, exp_sw(3'h7), 32'hFFFF8FFF);
      rdc(`DPS_A_ERR_CODE, {16'h0, fault_code}, 32'hFFFFFFFF);
      rdc(`DPS_A_VIEW, 32'h0000000F, 32'hFFFFFFFF);
      wexp = 1'b0;
      ctl(16'h0080, 3'h1);
      rdc(`DPS_A_ERR_CODE, 32'h00000000, 32'hFFFFFFFF);
      u_mst.wr(`DPS_A_CTRL, 32'h00000000);
      $display("test fault done");
      thr = $urandom_range(60000, 2000);
      hys = $urandom_range(1000, 1);
      u_mst.wr(`DPS_A_BAL_THR, thr);
      u_mst.wr(`DPS_A_BAL_HYS, hys);
      rdc(`DPS_A_BAL_THR, thr, 32'hFFFFFFFF);
      rdc(`DPS_A_BAL_HYS, hys, 32'hFFFFFFFF);
      sv = '{thr, thr - hys, thr - hys - 1, thr - 1, thr};
      @(posedge clk);
      for (int i = 0; i < 5; i++) begin
         supply_mv <= sv[i];
         repeat (4) @(posedge clk);
         chk1(ballast_on, 5'b10011 >> i);
      end
      u_mst.wr(`DPS_A_BAL_SET, 32'hFFFFFFFE);
      rdc(`DPS_A_BAL_SET, 32'h00000000, 32'hFFFFFFFF);
      chk1(ballast_on, 1'b0);
      u_mst.wr(`DPS_A_BAL_SET, 32'h00000001);
      repeat (4) @(posedge clk);
      chk1(ballast_on, 1'b1);
      $display("test ballast done");
      results();
   end
endmodule

// ==== design/dps_ballast.v ====
// ballast switch: voltage comparator with hysteresis and enable
`include "dps_regs.vh"

module dps_ballast #(
   parameter W = 32
) (
   input wire clk,
   input wire sys_rst,
   input wire enable,
   input wire [W-1:0] supply_mv,
   input wire [W-1:0] thr_mv,
   input wire [W-1:0] hys_mv,
   output reg on_q
);

   wire [W:0] low_mv;
   reg on_d;

   // lower switch point, clamped at zero so a large hysteresis cannot wrap
   assign low_mv = ({1'b0, thr_mv} > {1'b0, hys_mv}) ? ({1'b0, thr_mv} - {1'b0, hys_mv})
                                                     : {(W+1){1'b0}};

   always @* begin
      on_d = on_q;
      if (!enable) begin
         on_d = 1'b0;
      end else if (supply_mv >= thr_mv) begin
         on_d = 1'b1;
      end else if ({1'b0, supply_mv} < low_mv) begin
         on_d = 1'b0;
      end
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         on_q <= 1'b0;
      end else begin
         on_q <= on_d;
      end
   end

endmodule

// ==== design/dps_pwr_fsm.v ====
// power state machine of the drive
`include "dps_regs.vh"

module dps_pwr_fsm #(
   parameter FRA_CYC = `DPS_FRA_CYC
) (
   input wire clk,
   input wire sys_rst,
   input wire [15:0] ctrl,
   input wire fault_evt,
   input wire fr_pulse,
   output reg [2:0] state_q
);

   reg [2:0] state_d;
   reg [7:0] fra_cnt_q;
   wire so;
   wire ev;
   wire qs_n;
   wire eo;

   assign so = ctrl[`DPS_CW_SO];
   assign ev = ctrl[`DPS_CW_EV];
   assign qs_n = ctrl[`DPS_CW_QS];
   assign eo = ctrl[`DPS_CW_EO];

   always @* begin
      state_d = state_q;
      case (state_q)
         `DPS_ST_NRDY: state_d = `DPS_ST_SOD;
         `DPS_ST_SOD: begin
            if (ev && qs_n && !so) state_d = `DPS_ST_READY_TO_SWITCH_ON_FLAG;
         end
         `DPS_ST_READY_TO_SWITCH_ON_FLAG: begin
            if (!ev || !qs_n) state_d = `DPS_ST_SOD;
            else if (so && eo) state_d = `DPS_ST_OPEN;
            else if (so) state_d = `DPS_ST_SWON;
         end
         `DPS_ST_SWON: begin
            if (!ev || !qs_n) state_d = `DPS_ST_SOD;
            else if (!so) state_d = `DPS_ST_READY_TO_SWITCH_ON_FLAG;
            else if (eo) state_d = `DPS_ST_OPEN;
         end
         `DPS_ST_OPEN: begin
            if (!ev) state_d = `DPS_ST_SOD;
            else if (!qs_n) state_d = `DPS_ST_QSA;
            else if (!so) state_d = `DPS_ST_READY_TO_SWITCH_ON_FLAG;
            else if (!eo) state_d = `DPS_ST_SWON;
         end
         `DPS_ST_QSA: begin
            if (!ev) state_d = `DPS_ST_SOD;
            else if (qs_n && so && eo) state_d = `DPS_ST_OPEN;
         end
         `DPS_ST_FRA: begin
            if (fra_cnt_q == FRA_CYC[7:0] - 8'h01) state_d = `DPS_ST_FAULT;
         end
         `DPS_ST_FAULT: begin
            if (fr_pulse) state_d = `DPS_ST_SOD;
         end
         default: state_d = `DPS_ST_NRDY;
      endcase
      // a fault wins over any command, but not over its own reaction or the fault state
      if (fault_evt && state_q != `DPS_ST_FRA && state_q != `DPS_ST_FAULT) begin
         state_d = `DPS_ST_FRA;
      end
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= `DPS_ST_NRDY;
         fra_cnt_q <= 8'h00;
      end else begin
         state_q <= state_d;
         if (state_q == `DPS_ST_FRA) begin
            fra_cnt_q <= fra_cnt_q + 8'h01;
         end else begin
            fra_cnt_q <= 8'h00;
         end
      end
   end

endmodule

// ==== design/dps_regs.vh ====
// register offsets, field positions, reset values and timing counts of the drive object block
`ifndef DPS_REGS_VH
`define DPS_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DPS_A_BAL_SET 16'h4021
`define DPS_A_BAL_THR 16'h4022
`define DPS_A_BAL_HYS 16'h4023
`define DPS_A_VIEW 16'h4030
`define DPS_A_SERIAL 16'h4040
`define DPS_A_DEV_ID 16'h4041
`define DPS_A_BOOT_VER 16'h4042
`define DPS_A_BOOT_BUS 16'h4043
`define DPS_A_ERR_CODE 16'h603F
`define DPS_A_CTRL 16'h6040
`define DPS_A_STATUS 16'h6041

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DPS_RST_BAL_SET 32'h00000001
`define DPS_RST_THR_V1 32'h00012396
`define DPS_RST_THR_V2 32'h0000C596
`define DPS_RST_BAL_HYS 32'h000001F4
`define DPS_RST_ERR 16'h0000
`define DPS_RST_CTRL 16'h0000
`define DPS_RST_STATUS 16'h0000

// ----------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------
`define DPS_CW_SO 0
`define DPS_CW_EV 1
`define DPS_CW_QS 2
`define DPS_CW_EO 3
`define DPS_CW_FR 7
`define DPS_CW_HALT 8

// ----------------------------------------------------------------
// status word fields
// ----------------------------------------------------------------
`define DPS_SW_READY_TO_SWITCH_ON_FLAG 0
`define DPS_SW_SO 1
`define DPS_SW_OE 2
`define DPS_SW_FAULT 3
`define DPS_SW_VE 4
`define DPS_SW_QS 5
`define DPS_SW_SOD 6
`define DPS_SW_WARN 7
`define DPS_SW_SYNC 8
`define DPS_SW_REM 9
`define DPS_SW_TARGET_REACHED_FLAG 10
`define DPS_SW_ILA 11
`define DPS_SW_CLA 15

// ----------------------------------------------------------------
// power states
// ----------------------------------------------------------------
`define DPS_ST_NRDY 3'h0
`define DPS_ST_SOD 3'h1
`define DPS_ST_READY_TO_SWITCH_ON_FLAG 3'h2
`define DPS_ST_SWON 3'h3
`define DPS_ST_OPEN 3'h4
`define DPS_ST_QSA 3'h5
`define DPS_ST_FRA 3'h6
`define DPS_ST_FAULT 3'h7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DPS_FRA_CYC 4

`endif

// ==== design/dps_top.v ====
// drive object block: ballast settings, boot loader info, control and status words
//
// How it works
// - settings bit 0 enables ballast, preset on
// - ballast switches around threshold in millivolts
// - hysteresis below threshold, preset 1F4 hex
// - boot version: major high half, minor low
// - read-only supported fieldbus word
// - error code: low 16 bits, read-only
// - fault reset clears error code
// - control bit 0 requests switched on
// - control bit 1 requests voltage enabled
// - control bit 2 low requests quick stop
// - control bit 3 requests operation enabled
// - control bit 7 resets error or warning
// - control bit 8 halts in listed modes
// - status bits 0..2 show ready, on, enabled
// - status bit 5 low only in quick stop
// - status bit 6 shows switch-on disabled
// - status bit 8 shows fieldbus sync
// - status bit 9 always reads one
// - status bit 15: enabled and closed loop
// - low bits zero: bit 6 picks state
// - bits 5..0 encode ready, on, enabled, quick stop
// - 1111 fault reaction, 1000 fault
`include "dps_regs.vh"

module dps_top #(
   parameter VARIANT = 0,
   parameter FRA_CYC = `DPS_FRA_CYC,
   parameter [15:0] BOOT_MAJOR = 16'h0001,
   parameter [15:0] BOOT_MINOR = 16'h0000,
   parameter [31:0] BOOT_BUSES = 32'h00000000,
   // identity values below are arbitrary
   parameter [31:0] SERIAL_WORD = 32'h12345678,
   parameter [31:0] DEVICE_ID = 32'h00000000
) (
   input wire clk,
   input wire sys_rst,
   input wire [15:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   input wire [31:0] supply_mv,
   input wire fault_in,
   input wire [15:0] fault_code,
   input wire warning_in,
   input wire fieldbus_sync,
   input wire closed_loop_on,
   input wire target_reached_in,
   input wire internal_limit_in,
   input wire halt_mode_ok,
   output reg ballast_on,
   output reg halt_out,
   output reg power_stage_on
);

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   reg bal_en_q;
   reg [31:0] bal_thr_q;
   reg [31:0] bal_hys_q;
   reg [15:0] ctrl_q;
   reg [15:0] err_code_q;
   reg [15:0] status_q;
   reg [15:0] status_d;
   reg warn_q;
   reg fr_pulse_q;
   reg [31:0] rdata_d;

   wire [2:0] state;
   wire bal_sw;
   reg wr_bal_set;
   reg wr_bal_thr;
   reg wr_bal_hys;
   reg wr_ctrl;
   reg ballast_d;
   reg halt_d;
   reg pstage_d;
   wire fr_rise;
   wire in_fault;
   wire ve_window;

   localparam [31:0] THR_PRESET = (VARIANT == 0) ? `DPS_RST_THR_V1 : `DPS_RST_THR_V2;
   localparam [31:0] BAL_SET_PRESET = `DPS_RST_BAL_SET;

   // ----------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------
   always @* begin
      wr_bal_set = 1'b0;
      wr_bal_thr = 1'b0;
      wr_bal_hys = 1'b0;
      wr_ctrl = 1'b0;
      if (reg_wr) begin
         case (reg_addr)
            `DPS_A_BAL_SET: begin
               wr_bal_set = 1'b1;
            end
            `DPS_A_BAL_THR: begin
               wr_bal_thr = 1'b1;
            end
            `DPS_A_BAL_HYS: begin
               wr_bal_hys = 1'b1;
            end
            `DPS_A_CTRL: begin
               wr_ctrl = 1'b1;
            end
            default: begin
               wr_ctrl = 1'b0;
            end
         endcase
      end
   end

   // fault reset acts on the 0 to 1 step of the bit, not its level
   assign fr_rise = wr_ctrl && reg_wdata[`DPS_CW_FR] && !ctrl_q[`DPS_CW_FR];
   assign in_fault = (state == `DPS_ST_FAULT);
   assign ve_window = (state >= `DPS_ST_READY_TO_SWITCH_ON_FLAG) && (state <= `DPS_ST_QSA);

   // ----------------------------------------------------------------
   // ballast settings
   // ----------------------------------------------------------------
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bal_en_q <= BAL_SET_PRESET[0];
         bal_thr_q <= THR_PRESET;
         bal_hys_q <= `DPS_RST_BAL_HYS;
      end else begin
         if (wr_bal_set) begin
            bal_en_q <= reg_wdata[0];
         end
         if (wr_bal_thr) begin
            bal_thr_q <= reg_wdata;
         end
         if (wr_bal_hys) begin
            bal_hys_q <= reg_wdata;
         end
      end
   end

   dps_ballast #(
      .W(32)
   ) u_ballast (
      .clk(clk),
      .sys_rst(sys_rst),
      .enable(bal_en_q),
      .supply_mv(supply_mv),
      .thr_mv(bal_thr_q),
      .hys_mv(bal_hys_q),
      .on_q(bal_sw)
   );

   // ----------------------------------------------------------------
   // control word
   // ----------------------------------------------------------------
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q <= `DPS_RST_CTRL;
         fr_pulse_q <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= reg_wdata[15:0];
         end
         fr_pulse_q <= fr_rise;
      end
   end

   dps_pwr_fsm #(
      .FRA_CYC(FRA_CYC)
   ) u_fsm (
      .clk(clk),
      .sys_rst(sys_rst),
      .ctrl(ctrl_q),
      .fault_evt(fault_in),
      .fr_pulse(fr_pulse_q),
      .state_q(state)
   );

   // ----------------------------------------------------------------
   // error code and warning
   // ----------------------------------------------------------------
   // a new fault in the clearing cycle keeps its code
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         err_code_q <= `DPS_RST_ERR;
         warn_q <= 1'b0;
      end else begin
         if (fault_in) begin
            err_code_q <= fault_code;
         end else if (fr_pulse_q && in_fault) begin
            err_code_q <= `DPS_RST_ERR;
         end
         if (warning_in) begin
            warn_q <= 1'b1;
         end else if (fr_pulse_q) begin
            warn_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // status word
   // ----------------------------------------------------------------
   always @* begin
      status_d = 16'h0000;
      status_d[`DPS_SW_QS] = 1'b1;
      case (state)
         `DPS_ST_NRDY: begin
            status_d[`DPS_SW_SOD] = 1'b0;
         end
         `DPS_ST_SOD: begin
            status_d[`DPS_SW_SOD] = 1'b1;
         end
         `DPS_ST_READY_TO_SWITCH_ON_FLAG: begin
            status_d[`DPS_SW_READY_TO_SWITCH_ON_FLAG] = 1'b1;
         end
         `DPS_ST_SWON: begin
            status_d[`DPS_SW_READY_TO_SWITCH_ON_FLAG] = 1'b1;
            status_d[`DPS_SW_SO] = 1'b1;
         end
         `DPS_ST_OPEN: begin
            status_d[`DPS_SW_READY_TO_SWITCH_ON_FLAG] = 1'b1;
            status_d[`DPS_SW_SO] = 1'b1;
            status_d[`DPS_SW_OE] = 1'b1;
            status_d[`DPS_SW_CLA] = closed_loop_on;
         end
         `DPS_ST_QSA: begin
            status_d[`DPS_SW_READY_TO_SWITCH_ON_FLAG] = 1'b1;
            status_d[`DPS_SW_SO] = 1'b1;
            status_d[`DPS_SW_OE] = 1'b1;
            status_d[`DPS_SW_QS] = 1'b0;
         end
         `DPS_ST_FRA: begin
            status_d[3:0] = 4'hF;
         end
         `DPS_ST_FAULT: begin
            status_d[`DPS_SW_FAULT] = 1'b1;
         end
         default: begin
            status_d[`DPS_SW_SOD] = 1'b0;
         end
      endcase
      // voltage enabled shows only from ready to switch on through quick stop active, with control bit 1 set
      status_d[`DPS_SW_VE] = ctrl_q[`DPS_CW_EV] && ve_window;
      status_d[`DPS_SW_WARN] = warn_q;
      status_d[`DPS_SW_SYNC] = fieldbus_sync;
      status_d[`DPS_SW_REM] = 1'b1;
      status_d[`DPS_SW_TARGET_REACHED_FLAG] = target_reached_in;
      status_d[`DPS_SW_ILA] = internal_limit_in;
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         status_q <= `DPS_RST_STATUS;
      end else begin
         status_q <= status_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always @* begin
      ballast_d = bal_sw;
      // halt only acts in operation enabled, not in quick stop active or fault reaction active
      halt_d = ctrl_q[`DPS_CW_HALT] && halt_mode_ok && (state == `DPS_ST_OPEN);
      pstage_d = (state == `DPS_ST_OPEN) || (state == `DPS_ST_QSA) || (state == `DPS_ST_FRA);
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ballast_on <= 1'b0;
         halt_out <= 1'b0;
         power_stage_on <= 1'b0;
      end else begin
         ballast_on <= ballast_d;
         halt_out <= halt_d;
         power_stage_on <= pstage_d;
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   always @* begin
      rdata_d = 32'h00000000;
      if (reg_rd) begin
         case (reg_addr)
            `DPS_A_BAL_SET: begin
               rdata_d = {31'h00000000, bal_en_q};
            end
            `DPS_A_BAL_THR: begin
               rdata_d = bal_thr_q;
            end
            `DPS_A_BAL_HYS: begin
               rdata_d = bal_hys_q;
            end
            `DPS_A_VIEW: begin
               rdata_d = {26'h0000000, halt_out, bal_sw, warn_q, state};
            end
            `DPS_A_SERIAL: begin
               rdata_d = SERIAL_WORD;
            end
            `DPS_A_DEV_ID: begin
               rdata_d = DEVICE_ID;
            end
            `DPS_A_BOOT_VER: begin
               rdata_d = {BOOT_MAJOR, BOOT_MINOR};
            end
            `DPS_A_BOOT_BUS: begin
               rdata_d = BOOT_BUSES;
            end
            `DPS_A_ERR_CODE: begin
               rdata_d = {16'h0000, err_code_q};
            end
            `DPS_A_CTRL: begin
               rdata_d = {16'h0000, ctrl_q};
            end
            `DPS_A_STATUS: begin
               rdata_d = {16'h0000, status_q};
            end
            default: begin
               rdata_d = 32'h00000000;
            end
         endcase
      end
   end

   // data stands one cycle, then returns to zero
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 32'h00000000;
      end else begin
         reg_rdata <= rdata_d;
      end
   end

endmodule
